/* File: ccu_unit.sv */
// capture/compare/pwm unit with apb register slave
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
// What this block does
// - mode zero disables unit and resets state
// - modes pick falling, rising, fourth, sixteenth edge
// - mode 0010 toggles pin on match, flags
// - mode 1000 starts low, match forces high
// - mode 1001 starts high, match forces low
// - mode 1010 only flags; pin shows port latch
// - mode 1011 flags, resets timer, second starts adc
// - 11xx is pwm, ten-bit duty from bits
// - control bits 7:6 read zero; duty unused otherwise
// - control, low and high bytes read/write
// - capture/compare use timer one/three; pwm timer two
// - both units may share timers; pwm shares rate
// - capture copies selected timer count into value
// - capture sets flag; software clears it
// - new capture silently overwrites old value
// - second unit output pin writes can capture
// - prescaler cleared when off or leaving capture
// - prescale switch keeps count, may flag
// - second unit route bit picks port c (1) or b
// - timer assign bits choose third or first timer
// - compare value continuously against selected timer
// - timer write beats special event reset
module ccu_unit
  import ccu_pkg::*;
#(
  parameter bit UNIT_TWO = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CCU_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] first_timer_count,
  input wire logic [15:0] third_timer_count,
  input wire logic first_timer_write,
  input wire logic third_timer_write,
  input wire logic [7:0] pwm_timer_count,
  input wire logic [1:0] pwm_timer_fine,
  input wire logic pwm_period_match,
  input wire logic port_latch,
  input wire logic pin_direction,
  input wire logic port_c_pin_one_in,
  input wire logic port_b_pin_three_in,
  output logic port_c_pin_one_out,
  output logic port_c_pin_one_oe,
  output logic port_b_pin_three_out,
  output logic port_b_pin_three_oe,
  output logic unit_irq_flag,
  output logic special_event_first,
  output logic special_event_third,
  output logic adc_start
);

  // registers
  logic [5:0] unit_control_reg;
  logic [15:0] capture_compare_value_reg;
  logic [1:0] timer_assign_bits_reg;
  logic unit_two_pin_route_reg;
  logic flag_reg;
  logic [3:0] pre_cnt_reg;
  logic [3:0] pre_cnt_next;
  logic cmp_latch_reg;
  logic cmp_latch_next;
  logic match_prev_reg;
  logic c_sync1_reg, c_sync2_reg, b_sync1_reg, b_sync2_reg;
  logic pin_prev_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic pin_c_out_reg, pin_c_oe_reg, pin_b_out_reg, pin_b_oe_reg;
  logic spe_first_reg, spe_third_reg, adc_start_reg;

  // apb decode
  wire setup_phase = psel & ~penable;
  wire wr_access = psel & penable & pready_reg & pwrite;
  wire hit_ctl = (paddr == CCU_OFF_CONTROL);
  wire hit_low = (paddr == CCU_OFF_LOW);
  wire hit_high = (paddr == CCU_OFF_HIGH);
  wire hit_cfg = (paddr == CCU_OFF_CONFIG);
  wire hit_sts = (paddr == CCU_OFF_STATUS);
  wire hit_any = hit_ctl | hit_low | hit_high | hit_cfg | hit_sts;
  wire wr_ctl = wr_access & hit_ctl;
  wire wr_low = wr_access & hit_low;
  wire wr_high = wr_access & hit_high;
  wire wr_cfg = wr_access & hit_cfg;
  wire sts_clear = wr_access & hit_sts & pwdata[CCU_STS_FLAG_BIT];

  // mode decoding
  wire [3:0] mode = unit_control_reg[CCU_CTL_MODE_LSB +: 4];
  wire [1:0] duty_low_bits = unit_control_reg[CCU_CTL_DUTY_LSB +: 2];
  wire [3:0] new_mode = pwdata[CCU_CTL_MODE_LSB +: 4];
  ccu_class_t mode_class;
  assign mode_class = ccu_classify(mode);
  wire is_capture = (mode_class == CCU_CAPTURE);
  wire is_compare = (mode_class == CCU_COMPARE);
  wire is_pwm = (mode_class == CCU_PWM);

  // timer assignment: 1x third for both, 01 third for unit two only
  wire sel_third = timer_assign_bits_reg[1] |
                   ((timer_assign_bits_reg == CCU_ASSIGN_SPLIT) & UNIT_TWO);
  wire [15:0] timer_now = sel_third ? third_timer_count : first_timer_count;

  // pin selection: unit two follows the route bit
  wire use_port_c = ~UNIT_TWO | unit_two_pin_route_reg;
  wire pin_level = use_port_c ? c_sync2_reg : b_sync2_reg;
  wire pin_rise = pin_level & ~pin_prev_reg;
  wire pin_fall = ~pin_level & pin_prev_reg;

  // capture event selection with prescaler wrap
  wire div4_wrap = (pre_cnt_reg[1:0] == CCU_PRE4_LAST[1:0]);
  wire div16_wrap = (pre_cnt_reg == CCU_PRE16_LAST);
  wire cap_fire = ((mode == CCU_M_CAP_FALL) & pin_fall) |
                  ((mode == CCU_M_CAP_RISE) & pin_rise) |
                  ((mode == CCU_M_CAP_DIV4) & pin_rise & div4_wrap) |
                  ((mode == CCU_M_CAP_DIV16) & pin_rise & div16_wrap);
  wire pre_step = pin_rise & ((mode == CCU_M_CAP_DIV4) | (mode == CCU_M_CAP_DIV16));

  // compare: one event per entry into equality
  wire match_now = is_compare & (timer_now == capture_compare_value_reg);
  wire cmp_event = match_now & ~match_prev_reg;
  wire spe_event = cmp_event & (mode == CCU_M_SPECIAL);

  // pwm duty: eight high bits from low data byte, two from control
  wire [9:0] duty = {capture_compare_value_reg[7:0], duty_low_bits};
  wire duty_hit = ({pwm_timer_count, pwm_timer_fine} == duty);

  // pin drive: pwm and the toggle, set-high and set-low compare modes own the pin, others show port latch
  wire own_pin = is_pwm | (is_compare & (mode != CCU_M_SOFT_IRQ) &
                 (mode != CCU_M_SPECIAL));
  wire pin_drive = own_pin ? cmp_latch_reg : port_latch;

  // prescaler next value: cleared outside capture, kept across prescale changes
  always_comb begin
    pre_cnt_next = pre_cnt_reg;
    if (!is_capture) begin
      pre_cnt_next = CCU_PRE_ZERO;
    end else if (pre_step) begin
      pre_cnt_next = pre_cnt_reg + 4'h1;
    end
  end

  // compare output latch next value
  always_comb begin
    cmp_latch_next = cmp_latch_reg;
    if (wr_ctl && new_mode == CCU_M_SET_HIGH) begin
      cmp_latch_next = 1'b0;
    end else if (wr_ctl && new_mode == CCU_M_SET_LOW) begin
      cmp_latch_next = 1'b1;
    end else if (wr_ctl && new_mode == CCU_M_OFF) begin
      cmp_latch_next = 1'b0;
    end else if (mode == CCU_M_OFF) begin
      cmp_latch_next = 1'b0;
    end else if (cmp_event) begin
      case (mode)
        CCU_M_TOGGLE: cmp_latch_next = ~cmp_latch_reg;
        CCU_M_SET_HIGH: cmp_latch_next = 1'b1;
        CCU_M_SET_LOW: cmp_latch_next = 1'b0;
        default: cmp_latch_next = cmp_latch_reg;
      endcase
    end else if (is_pwm) begin
      if (duty_hit) cmp_latch_next = 1'b0;
      else if (pwm_period_match && duty != CCU_DUTY_ZERO) cmp_latch_next = 1'b1;
    end
  end

  // read mux
  wire [31:0] rd_mux = hit_ctl ? {26'h0, unit_control_reg} :
                       hit_low ? {24'h0, capture_compare_value_reg[7:0]} :
                       hit_high ? {24'h0, capture_compare_value_reg[15:8]} :
                       hit_cfg ? {29'h0, unit_two_pin_route_reg, timer_assign_bits_reg} :
                       hit_sts ? {31'h0, flag_reg} : 32'h0;

  // apb answer: registered one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~hit_any;
      prdata_reg <= (setup_phase & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_control_reg <= CCU_CTL_RST;
      timer_assign_bits_reg <= CCU_ASSIGN_RST;
      unit_two_pin_route_reg <= CCU_ROUTE_RST;
    end else begin
      if (wr_ctl) unit_control_reg <= pwdata[5:0];
      if (wr_cfg) timer_assign_bits_reg <= pwdata[CCU_CFG_ASSIGN_LSB +: 2];
      if (wr_cfg) unit_two_pin_route_reg <= pwdata[CCU_CFG_ROUTE_BIT];
    end
  end

  // value pair: capture overwrites, beating a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_compare_value_reg <= CCU_VAL_RST;
    end else if (cap_fire) begin
      capture_compare_value_reg <= timer_now;
    end else begin
      if (wr_low) capture_compare_value_reg[7:0] <= pwdata[7:0];
      if (wr_high) capture_compare_value_reg[15:8] <= pwdata[7:0];
    end
  end

  // sticky flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_reg <= 1'b0;
    else flag_reg <= (flag_reg & ~sts_clear) | cap_fire | cmp_event;
  end

  // pin synchronisers and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_sync1_reg <= 1'b0;
      c_sync2_reg <= 1'b0;
      b_sync1_reg <= 1'b0;
      b_sync2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      c_sync1_reg <= port_c_pin_one_in;
      c_sync2_reg <= c_sync1_reg;
      b_sync1_reg <= port_b_pin_three_in;
      b_sync2_reg <= b_sync1_reg;
      pin_prev_reg <= pin_level;
    end
  end

  // unit state: prescaler, compare latch, match history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= CCU_PRE_ZERO;
      cmp_latch_reg <= 1'b0;
      match_prev_reg <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
      cmp_latch_reg <= cmp_latch_next;
      match_prev_reg <= match_now;
    end
  end

  // special event pulses; a timer write that cycle takes precedence over the timer reset pulses, not adc_start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spe_first_reg <= 1'b0;
      spe_third_reg <= 1'b0;
      adc_start_reg <= 1'b0;
    end else begin
      spe_first_reg <= spe_event & ~sel_third & ~first_timer_write;
      spe_third_reg <= spe_event & sel_third & ~third_timer_write;
      adc_start_reg <= spe_event & UNIT_TWO;
    end
  end

  // pad drivers; direction low means the pad is an output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_c_out_reg <= 1'b0;
      pin_c_oe_reg <= 1'b0;
      pin_b_out_reg <= 1'b0;
      pin_b_oe_reg <= 1'b0;
    end else begin
      pin_c_out_reg <= use_port_c & pin_drive;
      pin_c_oe_reg <= use_port_c & ~pin_direction;
      pin_b_out_reg <= ~use_port_c & pin_drive;
      pin_b_oe_reg <= ~use_port_c & ~pin_direction;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign unit_irq_flag = flag_reg;
  assign special_event_first = spe_first_reg;
  assign special_event_third = spe_third_reg;
  assign adc_start = adc_start_reg;
  assign port_c_pin_one_out = pin_c_out_reg;
  assign port_c_pin_one_oe = pin_c_oe_reg;
  assign port_b_pin_three_out = pin_b_out_reg;
  assign port_b_pin_three_oe = pin_b_oe_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_div4_wrap;
    (mode == CCU_M_CAP_DIV4) && pin_rise && div4_wrap;
  endsequence

  sequence s_apb_read_ctl;
    setup_phase && !pwrite && hit_ctl;
  endsequence

  a_capture_loads_value: assert property (
    cap_fire |=> capture_compare_value_reg == $past(timer_now))
    else $error("capture did not load timer count");
  a_flag_on_capture: assert property (
    cap_fire |=> flag_reg)
    else $error("capture did not set flag");
  a_flag_stays_set: assert property (
    flag_reg && !sts_clear |=> flag_reg)
    else $error("flag dropped without clear");
  a_off_clears_prescaler: assert property (
    mode == CCU_M_OFF |=> pre_cnt_reg == CCU_PRE_ZERO)
    else $error("prescaler not cleared while off");
  a_div4_wraps: assert property (
    s_div4_wrap |-> cap_fire ##1 pre_cnt_reg[1:0] == CCU_PRE_ZERO[1:0])
    else $error("divide by four did not capture on wrap");
  a_set_high_match: assert property (
    mode == CCU_M_SET_HIGH && cmp_event && !wr_ctl |=> cmp_latch_reg)
    else $error("set high match did not drive high");
  a_toggle_match: assert property (
    mode == CCU_M_TOGGLE && cmp_event && !wr_ctl |=> cmp_latch_reg != $past(cmp_latch_reg))
    else $error("toggle match did not toggle");
  a_special_event: assert property (
    spe_event && !sel_third && !first_timer_write |=> special_event_first ##1 !special_event_first)
    else $error("special event pulse wrong");
  a_write_beats_event: assert property (
    first_timer_write |=> !special_event_first)
    else $error("special event issued during timer write");
  a_ctl_reads_zero_top: assert property (
    s_apb_read_ctl |=> pready && prdata[7:6] == 2'h0)
    else $error("control top bits not zero");
  a_fall_capture: assert property (
    mode == CCU_M_CAP_FALL && pin_fall |-> cap_fire)
    else $error("falling edge did not capture");
  a_div16_wraps: assert property (
    mode == CCU_M_CAP_DIV16 && pin_rise && div16_wrap |-> cap_fire)
    else $error("divide by sixteen did not capture on wrap");
  a_set_low_match: assert property (
    mode == CCU_M_SET_LOW && cmp_event && !wr_ctl |=> !cmp_latch_reg)
    else $error("set low match did not drive low");
  a_off_latch_low: assert property (
    wr_ctl && new_mode == CCU_M_OFF |=> !cmp_latch_reg)
    else $error("turning off did not clear output latch");
  a_soft_irq_pin: assert property (
    mode == CCU_M_SOFT_IRQ && use_port_c |=> port_c_pin_one_out == $past(port_latch))
    else $error("software interrupt mode moved the pin");
  a_compare_flag: assert property (
    cmp_event |=> flag_reg)
    else $error("compare match did not set flag");
  a_clear_drops_flag: assert property (
    sts_clear && !cap_fire && !cmp_event |=> !flag_reg)
    else $error("flag clear had no effect");
  a_adc_start: assert property (
    spe_event && UNIT_TWO |=> adc_start)
    else $error("special event did not start conversion");
  a_duty_clears_pin: assert property (
    is_pwm && duty_hit && !wr_ctl |=> !cmp_latch_reg)
    else $error("pwm duty match did not clear output");
  a_route_port_b: assert property (
    !use_port_c |=> !port_c_pin_one_oe && !port_c_pin_one_out)
    else $error("unselected port c pin still driven");
endmodule

/* File: ccu_pkg.sv */
// shared constants, register map and mode decoding for the capture/compare unit
package ccu_pkg;
  localparam int CCU_AW = 12;
  // register byte offsets on apb
  localparam logic [11:0] CCU_OFF_CONTROL = 12'h000;
  localparam logic [11:0] CCU_OFF_LOW = 12'h004;
  localparam logic [11:0] CCU_OFF_HIGH = 12'h008;
  localparam logic [11:0] CCU_OFF_CONFIG = 12'h00c;
  localparam logic [11:0] CCU_OFF_STATUS = 12'h010;
  // field positions
  localparam int CCU_CTL_MODE_LSB = 0;
  localparam int CCU_CTL_DUTY_LSB = 4;
  localparam int CCU_CFG_ASSIGN_LSB = 0;
  localparam int CCU_CFG_ROUTE_BIT = 2;
  localparam int CCU_STS_FLAG_BIT = 0;
  // reset values
  localparam logic [5:0] CCU_CTL_RST = 6'h00;
  localparam logic [15:0] CCU_VAL_RST = 16'h0000;
  localparam logic [1:0] CCU_ASSIGN_RST = 2'h0;
  localparam logic CCU_ROUTE_RST = 1'b1;
  // mode select encodings
  localparam logic [3:0] CCU_M_OFF = 4'h0;
  localparam logic [3:0] CCU_M_TOGGLE = 4'h2;
  localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCU_M_CAP_DIV4 = 4'h6;
  localparam logic [3:0] CCU_M_CAP_DIV16 = 4'h7;
  localparam logic [3:0] CCU_M_SET_HIGH = 4'h8;
  localparam logic [3:0] CCU_M_SET_LOW = 4'h9;
  localparam logic [3:0] CCU_M_SOFT_IRQ = 4'ha;
  localparam logic [3:0] CCU_M_SPECIAL = 4'hb;
  localparam logic [1:0] CCU_M_PWM_TOP = 2'h3;
  // timer assignment codes
  localparam logic [1:0] CCU_ASSIGN_SPLIT = 2'h1;
  // prescaler wrap points
  localparam logic [3:0] CCU_PRE4_LAST = 4'h3;
  localparam logic [3:0] CCU_PRE16_LAST = 4'hf;
  localparam logic [3:0] CCU_PRE_ZERO = 4'h0;
  localparam logic [9:0] CCU_DUTY_ZERO = 10'h000;

  typedef enum logic [2:0] {
    CCU_OFF, CCU_CAPTURE, CCU_COMPARE, CCU_PWM, CCU_RESERVED
  } ccu_class_t;

  // sorts a mode select value into its operating class
  function automatic ccu_class_t ccu_classify(input logic [3:0] m);
    ccu_class_t c;
    c = CCU_RESERVED;
    if (m == CCU_M_OFF) c = CCU_OFF;
    else if (m[3:2] == CCU_M_PWM_TOP) c = CCU_PWM;
    else if (m >= CCU_M_CAP_FALL && m <= CCU_M_CAP_DIV16) c = CCU_CAPTURE;
    else if (m == CCU_M_TOGGLE || (m >= CCU_M_SET_HIGH && m <= CCU_M_SPECIAL)) c = CCU_COMPARE;
    return c;
  endfunction
endpackage

/* File: ccu_timer_model.sv */
// model of the shared timers and pwm time base seen by the capture/compare unit
`timescale 1ns/1ns
module ccu_timer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic special_event_first,
  input wire logic special_event_third,
  output logic first_timer_write,
  output logic third_timer_write,
  output logic [15:0] first_timer_count,
  output logic [15:0] third_timer_count,
  output logic [7:0] pwm_timer_count,
  output logic [1:0] pwm_timer_fine,
  output logic pwm_period_match
);
  logic [9:0] pwm_reg;
  // a software load flags its cycle so the unit can hold back its special event
  assign first_timer_write = load;
  assign third_timer_write = load;
  // pwm time base split into count and fine bits, period at full scale
  assign pwm_timer_count = pwm_reg[9:2];
  assign pwm_timer_fine = pwm_reg[1:0];
  assign pwm_period_match = (pwm_reg == 10'h3ff);
  // both timers step on pclk, never asynchronously; a load beats an event reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_timer_count <= 16'h0000;
      third_timer_count <= 16'h0000;
      pwm_reg <= 10'h000;
    end else begin
      pwm_reg <= pwm_reg + 10'h001;
      if (load) begin
        first_timer_count <= load_val;
        third_timer_count <= load_val ^ 16'h5a5a; // third differs so a wrong pick shows
      end else begin
        if (special_event_first) first_timer_count <= 16'h0000;
        else if (run) first_timer_count <= first_timer_count + 16'h0001;
        if (special_event_third) third_timer_count <= 16'h0000;
        else if (run) third_timer_count <= third_timer_count + 16'h0001;
      end
    end
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the capture/compare unit over apb
`timescale 1ns/1ns
module testbench;
  import ccu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, route;
  logic [CCU_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] first_timer_count, third_timer_count, load_val, v, e;
  logic first_timer_write, third_timer_write, run, load, pwm_period_match;
  logic [7:0] pwm_timer_count;
  logic [1:0] pwm_timer_fine, asg;
  logic port_latch, pin_direction, pad_c, pad_b, c_in, b_in, c_out, c_oe, b_out, b_oe;
  logic unit_irq_flag, sev_first, sev_third, adc_start;
  logic [3:0] cm [4] = '{4'h8, 4'h9, 4'h2, 4'ha};
  logic [3:0] ci = 4'b1010;
  logic [3:0] cf = 4'b1101;
  int n_fail, compares, seed, i, k;
  // pad level is the unit's drive when enabled, else the outside driver
  assign c_in = c_oe ? c_out : pad_c;
  assign b_in = b_oe ? b_out : pad_b;
  ccu_unit #(.UNIT_TWO(1'b1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_timer_count(first_timer_count),
    .third_timer_count(third_timer_count), .first_timer_write(first_timer_write),
    .third_timer_write(third_timer_write), .pwm_timer_count(pwm_timer_count),
    .pwm_timer_fine(pwm_timer_fine), .pwm_period_match(pwm_period_match),
    .port_latch(port_latch), .pin_direction(pin_direction), .port_c_pin_one_in(c_in),
    .port_b_pin_three_in(b_in), .port_c_pin_one_out(c_out), .port_c_pin_one_oe(c_oe),
    .port_b_pin_three_out(b_out), .port_b_pin_three_oe(b_oe), .unit_irq_flag(unit_irq_flag),
    .special_event_first(sev_first), .special_event_third(sev_third), .adc_start(adc_start));
  ccu_timer_model tmr (.pclk(pclk), .presetn(presetn), .run(run), .load(load),
    .load_val(load_val), .special_event_first(sev_first), .special_event_third(sev_third),
    .first_timer_write(first_timer_write), .third_timer_write(third_timer_write),
    .first_timer_count(first_timer_count), .third_timer_count(third_timer_count),
    .pwm_timer_count(pwm_timer_count), .pwm_timer_fine(pwm_timer_fine),
    .pwm_period_match(pwm_period_match));
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // comparisons
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(rd, exp);
  endtask
  task automatic set_mode(input logic [3:0] m);
    apb(1'b1, CCU_OFF_CONTROL, {28'h0, m});
  endtask
  task automatic clr_flag();
    apb(1'b1, CCU_OFF_STATUS, 32'h1);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // drive the routed pad and leave time for sync, detect and capture
  task automatic pad_to(input logic l);
    @(posedge pclk);
    if (route) pad_c <= l;
    else pad_b <= l;
    ticks(6);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      pad_to(1'b1);
      pad_to(1'b0);
    end
  endtask
  task automatic set_timer(input logic [15:0] t);
    @(posedge pclk);
    load <= 1'b1;
    load_val <= t;
    @(posedge pclk);
    load <= 1'b0;
  endtask
  // unit two: code 00 takes the first timer, 01 and 1x the third
  function automatic logic [15:0] exp_time(input logic [1:0] a, input logic [15:0] t);
    return (a != 2'h0) ? (t ^ 16'h5a5a) : t;
  endfunction
  // pwm high cycles per period: none at zero duty, else restart through the duty count
  function automatic int exp_high(input logic [9:0] d);
    return (d == 10'h000) ? 0 : int'(d) + 1;
  endfunction
  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end
  // main sequence
  initial begin
    seed = 32'h6e8ea698;
    presetn = 1'b0;
    {psel, penable, pwrite, run, load, port_latch, pad_c, pad_b} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    load_val = 16'h0;
    pin_direction = 1'b1;
    route = 1'b1;
    n_fail = 0;
    compares = 0;
    ticks(12);
    presetn <= 1'b1;
    // reset values and an unmapped address
    rchk(CCU_OFF_CONTROL, 32'h0);
    rchk(CCU_OFF_LOW, 32'h0);
    rchk(CCU_OFF_HIGH, 32'h0);
    rchk(CCU_OFF_CONFIG, 32'h4);
    rchk(CCU_OFF_STATUS, 32'h0);
    apb(1'b1, 12'h014, 32'hff);
    chk1(err, 1'b1);
    rchk(12'h014, 32'h0);
    // random bytes read back; top control bits read zero
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      apb(1'b1, CCU_OFF_CONTROL, {24'h0, v[7:0]});
      rchk(CCU_OFF_CONTROL, {26'h0, v[5:0]});
      apb(1'b1, CCU_OFF_LOW, {24'h0, v[15:8]});
      rchk(CCU_OFF_LOW, {24'h0, v[15:8]});
      apb(1'b1, CCU_OFF_HIGH, {24'h0, v[7:0]});
      rchk(CCU_OFF_HIGH, {24'h0, v[7:0]});
    end
    set_mode(CCU_M_OFF);
    // rising captures over timer codes 00, 01 and 10 and both routes, second overwrites
    for (k = 0; k < 6; k++) begin
      asg = 2'(k % 3);
      route = (k < 3);
      apb(1'b1, CCU_OFF_CONFIG, {29'h0, route, asg});
      set_mode(CCU_M_CAP_RISE);
      clr_flag();
      for (i = 0; i < 2; i++) begin
        v = 16'($random(seed));
        set_timer(v);
        pulses(1);
        e = exp_time(asg, v);
        rchk(CCU_OFF_LOW, {24'h0, e[7:0]});
        rchk(CCU_OFF_HIGH, {24'h0, e[15:8]});
      end
      rchk(CCU_OFF_STATUS, 32'h1);
      chk1(unit_irq_flag, 1'b1);
      clr_flag();
      rchk(CCU_OFF_STATUS, 32'h0);
    end
    // falling edge mode ignores the rise
    set_mode(CCU_M_CAP_FALL);
    clr_flag();
    v = 16'($random(seed));
    set_timer(v);
    pad_to(1'b1);
    rchk(CCU_OFF_STATUS, 32'h0);
    pad_to(1'b0);
    rchk(CCU_OFF_STATUS, 32'h1);
    e = exp_time(asg, v);
    rchk(CCU_OFF_LOW, {24'h0, e[7:0]});
    // divide by 4 and 16 flag only on the last edge of a group
    for (k = 0; k < 2; k++) begin
      set_mode(CCU_M_OFF);
      set_mode(k ? CCU_M_CAP_DIV16 : CCU_M_CAP_DIV4);
      clr_flag();
      pulses(k ? 15 : 3);
      rchk(CCU_OFF_STATUS, 32'h0);
      pulses(1);
      rchk(CCU_OFF_STATUS, 32'h1);
    end
    // turning off clears a part count
    pulses(2);
    set_mode(CCU_M_OFF);
    set_mode(CCU_M_CAP_DIV4);
    clr_flag();
    pulses(3);
    rchk(CCU_OFF_STATUS, 32'h0);
    pulses(1);
    rchk(CCU_OFF_STATUS, 32'h1);
    // a direct prescale switch keeps the count of two
    set_mode(CCU_M_OFF);
    set_mode(CCU_M_CAP_DIV4);
    pulses(2);
    set_mode(CCU_M_CAP_DIV16);
    clr_flag();
    pulses(13);
    rchk(CCU_OFF_STATUS, 32'h0);
    pulses(1);
    rchk(CCU_OFF_STATUS, 32'h1);
    // compare pin actions on port c driven as an output
    apb(1'b1, CCU_OFF_CONFIG, 32'h4);
    pin_direction <= 1'b0;
    port_latch <= 1'b1;
    for (k = 0; k < 4; k++) begin
      v = {4'h1, 12'($random(seed))};
      apb(1'b1, CCU_OFF_LOW, {24'h0, v[7:0]});
      apb(1'b1, CCU_OFF_HIGH, {24'h0, v[15:8]});
      set_timer(v - 16'h0008);
      set_mode(CCU_M_OFF);
      set_mode(cm[k]);
      clr_flag();
      ticks(3);
      chk1(c_out, ci[k]);
      chk1(c_oe, 1'b1);
      chk1(b_oe, 1'b0);
      chk1(b_out, 1'b0);
      run <= 1'b1;
      ticks(20);
      run <= 1'b0;
      ticks(3);
      chk1(c_out, cf[k]);
      rchk(CCU_OFF_STATUS, 32'h1);
    end
    // special event: one-cycle timer reset and adc start
    set_mode(CCU_M_OFF);
    set_timer(v - 16'h0008);
    set_mode(CCU_M_SPECIAL);
    run <= 1'b1;
    i = 0;
    while (sev_first !== 1'b1 && i < 40) begin
      @(posedge pclk);
      i++;
    end
    chk1(sev_first, 1'b1);
    chk1(adc_start, 1'b1);
    chk1(sev_third, 1'b0);
    @(posedge pclk);
    chk1(sev_first, 1'b0);
    run <= 1'b0;
    // a timer load landing on the match holds the special event back
    clr_flag();
    @(posedge pclk);
    load <= 1'b1;
    load_val <= v;
    ticks(2);
    load <= 1'b0;
    @(posedge pclk);
    chk1(sev_first, 1'b0);
    rchk(CCU_OFF_STATUS, 32'h1);
    chk1(unit_irq_flag, 1'b1);
    // pwm: zero duty, then a random one below full scale
    for (k = 0; k < 2; k++) begin
      v = k ? {7'h0, 9'($random(seed))} : 16'h0000;
      apb(1'b1, CCU_OFF_LOW, {24'h0, v[9:2]});
      apb(1'b1, CCU_OFF_CONTROL, {26'h0, v[1:0], 4'hc});
      ticks(1100);
      i = 0;
      repeat (1024) begin
        @(posedge pclk);
        if (c_out === 1'b1) i++;
      end
      chk32(i, exp_high(v[9:0]));
    end
    // an output pad fed by the port latch still captures its own rise
    port_latch <= 1'b0;
    set_mode(CCU_M_CAP_RISE);
    ticks(6);
    clr_flag();
    port_latch <= 1'b1;
    ticks(6);
    rchk(CCU_OFF_STATUS, 32'h1);
    chk1(unit_irq_flag, 1'b1);
    stop_test();
  end
endmodule
